/* core/pba_pkg.sv */
// Purpose: shared constants and types for the bridge bus arbitration block
// Assumes: one clock (mclk), active-low asynchronous reset
// Notes:   secondary side has the bridge plus four external masters
`default_nettype none
package pba_pkg;
	localparam int NUM_EXT        = 4;
	localparam int NUM_MASTERS    = 5;
	localparam int BRIDGE_IDX     = 4;
	localparam int IDX_W          = 3;
	localparam int AD_W           = 32;
	localparam int CBE_W          = 4;
	// request backoff after disconnect, retry or abort, in PCI clocks
	localparam logic [1:0] BACKOFF_CYCLES = 2'h2;
	localparam logic [4:0] TIER_RESET     = 5'h10;
	localparam logic [2:0] LAST_RESET     = 3'h4;
	localparam logic [AD_W-1:0]  PARK_AD  = 32'h0000_0000;
	localparam logic [CBE_W-1:0] PARK_CBE = 4'h0;

	typedef enum logic [1:0] {
		PBA_P_IDLE    = 2'b00,
		PBA_P_REQUEST = 2'b01,
		PBA_P_BACKOFF = 2'b10,
		PBA_P_PARKED  = 2'b11
	} pba_pstate_type;
endpackage : pba_pkg
`default_nettype wire

/* core/pba_arb_if.sv */
// Purpose: carries request, tier and grant vectors between top and secondary arbiter
// Assumes: active-high vectors, bit 4 is the bridge
// Notes:   pin polarity is handled in the top module
`default_nettype none
interface pba_arb_if;
	logic [4:0] request;
	logic [4:0] highTier;
	logic       parkOnLast;
	logic       enable;
	logic [4:0] grant;
	modport top (output request, output highTier, output parkOnLast, output enable,
		input grant);
	modport arb (input request, input highTier, input parkOnLast, input enable,
		output grant);
endinterface : pba_arb_if
`default_nettype wire

/* core/pba_sec_arbiter.sv */
// Purpose: two-tier round-robin secondary arbiter with parking
// Assumes: requests are already synchronised, active high
// Notes:   one grant at most, changed only at a clock edge
`default_nettype none
module pba_sec_arbiter (
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// arbiter link
	pba_arb_if.arb    arb
);
	logic [4:0] grant;
	logic [2:0] last;
	logic [4:0] next_grant;
	logic [2:0] next_last;

	// round-robin pick among a mask, starting after the last winner
	function automatic logic [3:0] pickRr(input logic [4:0] m, input logic [2:0] after);
		logic [3:0] r;
		logic [2:0] idx;
		r = 4'h0;
		for (int k = 5; k >= 1; k--) begin
			idx = 3'((32'(after) + k) % 5);
			if (m[idx])
				r = {1'b1, idx};
		end
		return r;
	endfunction

	wire [4:0] hiReq  = arb.request & arb.highTier;
	wire [4:0] loReq  = arb.request & ~arb.highTier;
	wire [3:0] hiPick = pickRr(hiReq, last);
	wire [3:0] loPick = pickRr(loReq, last);
	// keep the bus while the owner still requests, so a grant never flips mid-use
	wire       holdIt = |(grant & arb.request);

	always_comb begin
		next_grant = grant;
		next_last  = last;
		if (!arb.enable)
			next_grant = 5'h00;
		else if (holdIt)
			next_grant = grant;
		else if (hiPick[3]) begin
			next_grant = 5'(5'h01 << hiPick[2:0]);
			next_last  = hiPick[2:0];
		end else if (loPick[3]) begin
			next_grant = 5'(5'h01 << loPick[2:0]);
			next_last  = loPick[2:0];
		end else if (arb.parkOnLast)
			next_grant = 5'(5'h01 << last);
		else
			next_grant = 5'(5'h01 << pba_pkg::BRIDGE_IDX);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			grant <= 5'h00;
			last  <= pba_pkg::LAST_RESET;
		end else begin
			grant <= next_grant;
			last  <= next_last;
		end
	end

	assign arb.grant = grant;
endmodule : pba_sec_arbiter
`default_nettype wire

/* core/pba_bus_arbitration.sv */
// Purpose: primary request/parking logic and secondary arbiter front end
// Assumes: one PCI clock; queue status and termination flags come from bridge logic
// Notes:   pins are sampled through three flops; strap captured after reset release
//
// Operation
// - request primary bus whenever an upstream transaction must be forwarded
// - keep primary request asserted while posted writes or delayed requests queue
// - after disconnect, retry or abort drop primary request for two clocks
// - when granted, start on first clock after primary bus sampled idle
// - granted without requesting: park address/data, byte enables, parity
// - while parked and granted, may start next clock without requesting
// - without grant never start; request again and wait
// - secondary arbiter serves bridge plus four external masters
// - higher tier wins over lower tier, except that a current owner keeps the bus while it still requests
// - tier of each master is selected by configuration
// - strap low enables internal arbiter, high disables it
// - strap high: request 0 is bridge grant, grant 0 bridge request
// - external arbiter in use: grants 1 to 3 float
// - all secondary pins active low; round-robin tiers, bridge high by default
// - idle secondary bus parks on bridge or last master, by configuration
`default_nettype none
module pba_bus_arbitration (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// bridge-side demand
	input  wire logic        upstreamPending,
	input  wire logic        secondaryNeedsBus,
	input  wire logic        primaryTermRetry,
	input  wire logic        primaryTermDisconnect,
	input  wire logic        primaryTermAbort,
	input  wire logic        primaryCycleDone,
	// primary pins
	output logic             primaryRequest_n,
	input  wire logic        primaryGrant_n,
	input  wire logic        primaryFrame_n,
	input  wire logic        primaryIrdy_n,
	output logic             primaryStart,
	output logic             primaryParked,
	output logic [31:0]      primary_addr_data,
	output logic [3:0]       primaryCbe,
	output logic             primary_parity,
	output logic             primaryParkOe_n,
	// secondary pins
	input  wire logic [3:0]  secondary_master_request_n,
	output logic [3:0]       secondary_master_grant_n,
	output logic [3:0]       secondaryGrantOe_n,
	input  wire logic        internal_arbiter_disable_strap,
	// configuration
	input  wire logic [4:0]  tierHigh,
	input  wire logic        parkOnLastMaster,
	// secondary bridge status
	output logic             secondaryBridgeGranted
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] gntSync;
	logic [2:0] idleSync;
	logic [3:0] reqS1, reqS2, reqS3;
	logic [2:0] strapSync;
	logic [2:0] strapFill;
	logic       strapHigh;
	logic       strapTaken;
	logic [3:0] reqClean;
	logic       gntClean;
	logic       idleClean;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			// reset contents match the clean flops, so no false grant or request follows reset
			gntSync   <= 3'h0;
			idleSync  <= 3'h7;
			reqS1     <= 4'h0;
			reqS2     <= 4'h0;
			reqS3     <= 4'h0;
			strapSync <= 3'h0;
		end else begin
			gntSync   <= {gntSync[1:0], ~primaryGrant_n};
			idleSync  <= {idleSync[1:0], primaryFrame_n & primaryIrdy_n};
			reqS1     <= ~secondary_master_request_n;
			reqS2     <= reqS1;
			reqS3     <= reqS2;
			strapSync <= {strapSync[1:0], internal_arbiter_disable_strap};
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			gntClean  <= 1'b0;
			idleClean <= 1'b1;
			reqClean  <= 4'h0;
		end else begin
			if (gntSync[1] == gntSync[2])
				gntClean <= gntSync[2];
			if (idleSync[1] == idleSync[2])
				idleClean <= idleSync[2];
			for (int i = 0; i < 4; i++)
				if (reqS2[i] == reqS3[i])
					reqClean[i] <= reqS3[i];
		end
	end

	// strap is caught once, after release, when the synchroniser agrees;
	// its reset contents are not the strap, so wait until they are flushed
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			strapHigh  <= 1'b0;
			strapTaken <= 1'b0;
			strapFill  <= 3'h0;
		end else begin
			strapFill <= {strapFill[1:0], 1'b1};
			if (strapFill[2] && !strapTaken && strapSync[1] == strapSync[2]) begin
				strapHigh  <= strapSync[2];
				strapTaken <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// primary request and parking
	// ----------------------------------------------------------------
	pba_pkg::pba_pstate_type pState, next_pState;
	logic [1:0] backoff;
	logic [1:0] next_backoff;
	wire        termBack = primaryTermRetry | primaryTermDisconnect | primaryTermAbort;
	wire        wantReq  = upstreamPending;
	wire        startNow = gntClean & idleClean & wantReq;

	always_comb begin
		next_pState  = pState;
		next_backoff = backoff;
		case (pState)
			pba_pkg::PBA_P_IDLE: begin
				if (gntClean)
					next_pState = pba_pkg::PBA_P_PARKED;
				else if (wantReq)
					next_pState = pba_pkg::PBA_P_REQUEST;
			end
			pba_pkg::PBA_P_REQUEST: begin
				if (termBack) begin
					next_pState  = pba_pkg::PBA_P_BACKOFF;
					next_backoff = pba_pkg::BACKOFF_CYCLES;
				end else if (!wantReq && primaryCycleDone)
					next_pState = pba_pkg::PBA_P_IDLE;
			end
			pba_pkg::PBA_P_BACKOFF: begin
				next_backoff = backoff - 2'h1;
				if (backoff == 2'h1)
					next_pState = wantReq ? pba_pkg::PBA_P_REQUEST : pba_pkg::PBA_P_IDLE;
			end
			pba_pkg::PBA_P_PARKED: begin
				if (!gntClean)
					next_pState = wantReq ? pba_pkg::PBA_P_REQUEST
						: pba_pkg::PBA_P_IDLE;
				else if (wantReq)
					next_pState = pba_pkg::PBA_P_REQUEST;
			end
			default: next_pState = pba_pkg::PBA_P_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pState  <= pba_pkg::PBA_P_IDLE;
			backoff <= 2'h0;
		end else begin
			pState  <= next_pState;
			backoff <= next_backoff;
		end
	end

	wire reqActive = (pState == pba_pkg::PBA_P_REQUEST);
	wire parkNow   = (pState == pba_pkg::PBA_P_PARKED);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			primaryRequest_n  <= 1'b1;
			primaryStart      <= 1'b0;
			primaryParked     <= 1'b0;
			primaryParkOe_n   <= 1'b1;
			primary_addr_data <= pba_pkg::PARK_AD;
			primaryCbe        <= pba_pkg::PARK_CBE;
			primary_parity    <= 1'b0;
		end else begin
			// backoff state keeps request high for exactly two clocks
			primaryRequest_n <= ~(next_pState == pba_pkg::PBA_P_REQUEST);
			// start only while the grant is still seen
			primaryStart     <= (reqActive | parkNow) & startNow;
			primaryParked    <= parkNow;
			primaryParkOe_n  <= ~(parkNow & gntClean);
			primary_addr_data <= pba_pkg::PARK_AD;
			primaryCbe        <= pba_pkg::PARK_CBE;
			primary_parity    <= ^{pba_pkg::PARK_AD, pba_pkg::PARK_CBE};
		end
	end

	// ----------------------------------------------------------------
	// secondary arbitration
	// ----------------------------------------------------------------
	pba_arb_if arbLink ();

	assign arbLink.request    = {secondaryNeedsBus, reqClean};
	assign arbLink.highTier   = tierHigh;
	assign arbLink.parkOnLast = parkOnLastMaster;
	assign arbLink.enable     = strapTaken & ~strapHigh;

	pba_sec_arbiter secArb (
		.mclk (mclk),
		.nrst (nrst),
		.arb  (arbLink.arb)
	);

	// external mode: request 0 is our grant, grant 0 is our request
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			secondary_master_grant_n <= 4'hf;
			secondaryGrantOe_n       <= 4'hf;
			secondaryBridgeGranted   <= 1'b0;
		end else if (strapHigh) begin
			secondary_master_grant_n <= {3'h7, ~secondaryNeedsBus};
			secondaryGrantOe_n       <= 4'he;
			secondaryBridgeGranted   <= reqClean[0];
		end else begin
			secondary_master_grant_n <= ~arbLink.grant[3:0];
			secondaryGrantOe_n       <= {4{~strapTaken}};
			secondaryBridgeGranted   <= arbLink.grant[pba_pkg::BRIDGE_IDX];
		end
	end
endmodule : pba_bus_arbitration
`default_nettype wire

/* tb/pba_arb_properties.sv */
// Purpose: port-level properties of the bus arbitration block
// Assumes: strap changes only while nrst is low
// Notes:   counts kept short, bodies unseen
`default_nettype none
module pba_arb_properties (
	// clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// primary side
	input wire logic        upstreamPending,
	input wire logic        primaryTermRetry,
	input wire logic        primaryTermDisconnect,
	input wire logic        primaryTermAbort,
	input wire logic        primaryRequest_n,
	input wire logic        primaryGrant_n,
	input wire logic        primaryStart,
	input wire logic [31:0] primary_addr_data,
	input wire logic [3:0]  primaryCbe,
	input wire logic        primary_parity,
	input wire logic        primaryParkOe_n,
	// secondary side
	input wire logic        secondaryNeedsBus,
	input wire logic [3:0]  secondary_master_grant_n,
	input wire logic [3:0]  secondaryGrantOe_n,
	input wire logic        internal_arbiter_disable_strap
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire term = primaryTermRetry | primaryTermDisconnect | primaryTermAbort;
	sequence termSeen; term; endsequence
	sequence extMode; internal_arbiter_disable_strap [*8]; endsequence
	a_one_grant: assert property ($onehot0(~secondary_master_grant_n))
		else $error("two secondary grants");
	a_backoff_two: assert property (termSeen |=> primaryRequest_n [*2])
		else $error("request not dropped two clocks");
	a_req_pending: assert property ((upstreamPending && !term) [*3] |=> !primaryRequest_n)
		else $error("request missing while pending");
	a_park_parity: assert property (!primaryParkOe_n |->
		primary_parity == ^{primary_addr_data, primaryCbe})
		else $error("park parity wrong");
	a_no_start: assert property (primaryGrant_n [*8] |-> !primaryStart)
		else $error("start without grant");
	a_int_oe: assert property ((!internal_arbiter_disable_strap) [*8] |->
		secondaryGrantOe_n == 4'h0)
		else $error("internal grants not driven");
	a_ext_float: assert property (extMode |-> secondaryGrantOe_n == 4'he)
		else $error("external grants driven");
	a_ext_req: assert property ((internal_arbiter_disable_strap && $stable(secondaryNeedsBus)) [*8]
		|-> secondary_master_grant_n[0] == !secondaryNeedsBus)
		else $error("bridge request pin wrong");
endmodule // pba_arb_properties
`default_nettype wire

/* tb/pba_far_side.sv */
// Purpose: primary arbiter and four secondary masters facing the block
// Assumes: pins change just after each rising edge
// Notes:   masters hold their request while demand stays high
`default_nettype none
module pba_far_side (
	// clock
	input  wire logic       mclk,
	// bench controls
	input  wire logic       giveGrant,
	input  wire logic       busBusy,
	input  wire logic [3:0] demand,
	// block pins
	input  wire logic       primaryRequest_n,
	output logic            primaryGrant_n = 1'h1,
	output logic            primaryFrame_n = 1'h1,
	output logic            primaryIrdy_n = 1'h1,
	output logic [3:0]      secondary_master_request_n = 4'hf
);
	timeunit 1ns;
	timeprecision 1ns;
	// grant follows the request, or is handed over unasked to park the bus
	always @(posedge mclk) begin
		primaryGrant_n <= !(giveGrant || !primaryRequest_n);
		primaryFrame_n <= !busBusy;
		primaryIrdy_n <= !busBusy;
		secondary_master_request_n <= ~demand;
	end
endmodule // pba_far_side
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for the bus arbitration block
// Assumes: inputs change on falling edges
// Notes:   strap is changed only while reset is held
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [4:0] tier;
		logic [3:0] want;
		logic       needs;
		logic [3:0] gnt;
		logic       own;
	} pba_row_type;
	localparam pba_row_type ROWS [9] = '{'{5'h10, 4'h1, 1'h0, 4'he, 1'h0},
		'{5'h10, 4'h8, 1'h0, 4'h7, 1'h0}, '{5'h10, 4'h0, 1'h1, 4'hf, 1'h1},
		'{5'h04, 4'h6, 1'h0, 4'hb, 1'h0}, '{5'h02, 4'h6, 1'h0, 4'hd, 1'h0},
		'{5'h01, 4'h9, 1'h0, 4'he, 1'h0}, '{5'h08, 4'h9, 1'h0, 4'h7, 1'h0},
		'{5'h10, 4'h5, 1'h0, 4'he, 1'h0}, '{5'h10, 4'h5, 1'h0, 4'hb, 1'h0}};
	logic mclk = 1'h0, nrst = 1'h0, upstreamPending = 1'h0, secondaryNeedsBus = 1'h0;
	logic primaryTermRetry = 1'h0, primaryTermDisconnect = 1'h0, primaryTermAbort = 1'h0;
	logic primaryCycleDone = 1'h0, internal_arbiter_disable_strap = 1'h0;
	logic parkOnLastMaster = 1'h0, giveGrant = 1'h0, busBusy = 1'h0;
	logic [3:0] demand = 4'h0;
	logic [4:0] tierHigh = 5'h10;
	logic primaryGrant_n, primaryFrame_n, primaryIrdy_n, primaryRequest_n, primaryStart;
	logic primaryParked, primary_parity, primaryParkOe_n, secondaryBridgeGranted;
	logic [31:0] primary_addr_data;
	logic [3:0] primaryCbe, secondary_master_request_n, secondary_master_grant_n;
	logic [3:0] secondaryGrantOe_n;
	int nErrors = 0, samplesChecked = 0, cycles = 0;
	pba_bus_arbitration pba_bus_arbitration_inst (.*);
	pba_far_side pba_far_side_inst (.*);
	always #25 mclk = ~mclk;
	// a hung handshake is cut short well past the expected run length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			nErrors++;
			summarize();
		end
	end
	task automatic waitCycles(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		waitCycles(12);
		chk("reset req", 1'h1, primaryRequest_n);
		chk("reset oe", 4'hf, secondaryGrantOe_n);
		nrst = 1'h1;
		waitCycles(8);
		chk("int oe", 4'h0, secondaryGrantOe_n);
		$display("reset done");
		foreach (ROWS[i]) begin
			tierHigh = ROWS[i].tier;
			demand = ROWS[i].want;
			secondaryNeedsBus = ROWS[i].needs;
			waitCycles(10);
			chk("grant", ROWS[i].gnt, secondary_master_grant_n);
			chk("bridge own", ROWS[i].own, secondaryBridgeGranted);
			demand = 4'h0;
			secondaryNeedsBus = 1'h0;
			waitCycles(10);
			chk("idle grant", 4'hf, secondary_master_grant_n);
			$display("row %0d done", i);
		end
		parkOnLastMaster = 1'h1;
		demand = 4'h2;
		waitCycles(10);
		demand = 4'h0;
		waitCycles(10);
		chk("park last", 4'hd, secondary_master_grant_n);
		$display("parking done");
		upstreamPending = 1'h1;
		waitCycles(3);
		chk("req", 1'h0, primaryRequest_n);
		busBusy = 1'h1;
		waitCycles(8);
		chk("start busy", 1'h0, primaryStart);
		busBusy = 1'h0;
		waitCycles(8);
		chk("start idle", 1'h1, primaryStart);
		for (int k = 0; k < 3; k++) begin
			{primaryTermAbort, primaryTermDisconnect, primaryTermRetry} = 3'(1 << k);
			waitCycles(1);
			{primaryTermAbort, primaryTermDisconnect, primaryTermRetry} = 3'h0;
			chk("backoff", 1'h1, primaryRequest_n);
			waitCycles(4);
			chk("req again", 1'h0, primaryRequest_n);
		end
		// queue drained: the cycle ends normally, then the arbiter parks the bus on us
		upstreamPending = 1'h0;
		primaryCycleDone = 1'h1;
		giveGrant = 1'h1;
		waitCycles(1);
		primaryCycleDone = 1'h0;
		waitCycles(7);
		chk("park oe", 1'h0, primaryParkOe_n);
		chk("parked", 1'h1, primaryParked);
		chk("park ad", pba_pkg::PARK_AD, primary_addr_data);
		chk("park cbe", pba_pkg::PARK_CBE, primaryCbe);
		chk("park par", ^{pba_pkg::PARK_AD, pba_pkg::PARK_CBE}, primary_parity);
		upstreamPending = 1'h1;
		waitCycles(1);
		chk("park start", 1'h1, primaryStart);
		upstreamPending = 1'h0;
		primaryCycleDone = 1'h1;
		giveGrant = 1'h0;
		waitCycles(1);
		primaryCycleDone = 1'h0;
		waitCycles(8);
		chk("unpark oe", 1'h1, primaryParkOe_n);
		chk("no start", 1'h0, primaryStart);
		$display("primary done");
		nrst = 1'h0;
		internal_arbiter_disable_strap = 1'h1;
		waitCycles(2);
		chk("reset ext oe", 4'hf, secondaryGrantOe_n);
		nrst = 1'h1;
		secondaryNeedsBus = 1'h1;
		waitCycles(8);
		chk("ext oe", 4'he, secondaryGrantOe_n);
		chk("ext req", 1'h0, secondary_master_grant_n[0]);
		demand = 4'h1;
		waitCycles(8);
		chk("ext own", 1'h1, secondaryBridgeGranted);
		$display("external done");
		summarize();
	end
endmodule // tb_top
bind pba_bus_arbitration pba_arb_properties pba_arb_properties_inst (.*);
`default_nettype wire
